// ---- rhps_dev_model.sv ----
// Behavioural USB device seen at the downstream port pins
`timescale 1ns/10ps
module rhps_dev_model (
  input  wire logic           sys_clk_i,
  output rhps_pkg::rhps_port_t port_o
);
  import rhps_pkg::*;
  initial port_o = '0;
  // Plug in or pull out the device
  task automatic plug(input logic v);
    @(posedge sys_clk_i);
    port_o.attach <= v;
  endtask : plug
  // Wake held long enough for the two-flop sampling to see it
  task automatic wake();
    @(posedge sys_clk_i);
    port_o.remote_resume <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    port_o.remote_resume <= 1'b0;
  endtask : wake
  // Fault pulse: 0 overcurrent, 1 power off, 2 bus error
  task automatic fault(input int i);
    @(posedge sys_clk_i);
    port_o[3-i] <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    port_o[3-i] <= 1'b0;
  endtask : fault
endmodule : rhps_dev_model

// ---- rhps_pkg.sv ----
// Package for the root hub port status low-bit logic
package rhps_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] RHPS_ADDR_PORT   = 8'h00;  // Port status/command
  localparam logic [7:0] RHPS_ADDR_CHANGE = 8'h04;  // Change flags, w1c
  localparam logic [7:0] RHPS_ADDR_CTRL   = 8'h08;  // Port control

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int RHPS_BIT_ATTACH  = 0;  // Read attach / write clear enable
  localparam int RHPS_BIT_ENABLE  = 1;  // Read enabled / write set enable
  localparam int RHPS_BIT_SUSPEND = 2;  // Read suspended / write suspend
  localparam int RHPS_BIT_RESET   = 4;  // Read reset active / write reset
  localparam int RHPS_CHG_ATTACH  = 0;  // Attach change flag
  localparam int RHPS_CHG_ENABLE  = 1;  // Enable change flag
  localparam int RHPS_CHG_SUSPEND = 2;  // Suspend change flag
  localparam int RHPS_CHG_RESET   = 4;  // Reset change flag
  localparam int RHPS_CTL_NONREM  = 0;  // Port holds a nonremovable device

  // ----------------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------------
  localparam int RHPS_CLK_MHZ       = 200;  // System clock rate
  localparam int RHPS_RESET_US      = 10;   // Port reset signalling time
  localparam int RHPS_RESUME_US     = 20;   // Resume signalling time
  localparam int RHPS_RESET_CYCLES  = RHPS_RESET_US * RHPS_CLK_MHZ;
  localparam int RHPS_RESUME_CYCLES = RHPS_RESUME_US * RHPS_CLK_MHZ;
  localparam int RHPS_CNT_W         = 16;   // Timer width

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] RHPS_RD_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Port state machine
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RHPS_IDLE      = 2'b00,  // Normal, possibly enabled
    RHPS_RESETTING = 2'b01,  // Driving reset on the port
    RHPS_SUSPENDED = 2'b10,  // Port suspended
    RHPS_RESUMING  = 2'b11   // Resume signalling in progress
  } rhps_state_t;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;   // Byte address
    logic [31:0] wdata;  // Write data
    logic        wr;     // Write strobe
    logic        rd;     // Read strobe
  } rhps_bus_t;

  // Downstream port events
  typedef struct packed {
    logic attach;        // Device present on the port
    logic overcurrent;   // Overcurrent detected
    logic power_off;     // Port power switched off
    logic bus_error;     // Operational bus error
    logic remote_resume; // Resume signalled from downstream
  } rhps_port_t;

endpackage : rhps_pkg

// ---- rhps_port.sv ----
// Root hub port status low bits: suspend, enable and attach handling
// Operation
// - Suspend write sets suspend, else attach change
// - Resume end clears suspend, sets change
// - Reset end or controller resume clears suspend; here a reset write clears it when the reset starts
// - Downstream resume is forwarded to controller while suspended
// - Fault clearing enable sets enable change
// - Reset or resume completion sets enable
// - Enable write sets enable, else attach change
// - Attach bit reads live port state
// - Writing one at bit zero clears enable
// - Port register writes never change the attach value
// - Nonremovable port always reads attached
// - Suspend and enable bits read their state
// - Reset write without device sets attach change
`timescale 1ns/10ps
module rhps_port (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  input  wire rhps_pkg::rhps_bus_t  bus_i,
  output logic [31:0]               rdata_o,
  input  wire rhps_pkg::rhps_port_t port_i,
  input  wire logic                 controller_resume_state_i,
  output logic                      port_reset_drive_o,
  output logic                      port_resume_drive_o,
  output logic                      resume_to_controller_o
);
  import rhps_pkg::*;

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  // All port pins are levels from the far side with no relation to our
  // clock, so every one of them passes the two-flop chain before any
  // decision reads it. The cost is two cycles of latency on every port
  // event, which is far below any timing the port protocol cares about.
  // Pins are flattened so one synchroniser instance covers the whole set.
  rhps_port_t port_s;        // Port pins after two flops
  logic [4:0] port_raw;      // Flattened pins
  logic [4:0] port_syn;      // Flattened synchronised pins

  assign port_raw = port_i;
  assign port_s   = port_syn;

  rhps_sync #(.W(5)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .d_i       (port_raw),
    .q_o       (port_syn)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  rhps_state_t           state;                  // Port sequence state
  rhps_state_t           next_state;
  logic [RHPS_CNT_W-1:0] timer;                  // Reset/resume timer
  logic [RHPS_CNT_W-1:0] next_timer;
  logic                  port_enabled_flag;      // Port enabled
  logic                  next_port_enabled_flag;
  logic                  attach_change_flag;     // Attach changed
  logic                  next_attach_change_flag;
  logic                  enable_change_flag;     // Enable cleared by fault
  logic                  next_enable_change_flag;
  logic                  suspend_change_flag;    // Resume completed
  logic                  next_suspend_change_flag;
  logic                  reset_change_flag;      // Reset completed
  logic                  next_reset_change_flag;
  logic                  nonremovable_port_mask; // Port is fixed device
  logic                  next_nonremovable_port_mask;
  logic                  attach_prev;            // Attach one cycle ago
  logic                  next_attach_prev;
  logic [31:0]           next_rdata;

  // ----------------------------------------------------------------------
  // Decoded strobes
  // ----------------------------------------------------------------------
  logic wr_port;                                 // Write to port register
  logic wr_chg;                                  // Write to change flags
  logic wr_ctl;                                  // Write to control
  logic device_attached_flag;                    // Reported attach state
  logic port_suspended_flag;                     // Suspended or resuming
  logic port_reset_active_flag;                  // Reset signalling
  logic fault;                                   // Any enable-killing event
  logic disconnect;                              // Falling attach edge

  assign wr_port = bus_i.wr && (bus_i.addr == RHPS_ADDR_PORT);
  assign wr_chg  = bus_i.wr && (bus_i.addr == RHPS_ADDR_CHANGE);
  assign wr_ctl  = bus_i.wr && (bus_i.addr == RHPS_ADDR_CTRL);

  assign device_attached_flag = port_s.attach || nonremovable_port_mask;
  assign port_suspended_flag  = (state == RHPS_SUSPENDED) ||
                                (state == RHPS_RESUMING);
  assign port_reset_active_flag = (state == RHPS_RESETTING);
  assign disconnect = attach_prev && !device_attached_flag;
  assign fault = disconnect || port_s.overcurrent || port_s.power_off ||
                 port_s.bus_error;

  // Drives toward the port and the controller
  assign port_reset_drive_o  = port_reset_active_flag;
  assign port_resume_drive_o = (state == RHPS_RESUMING);
  assign resume_to_controller_o = (state == RHPS_SUSPENDED) &&
                                  port_s.remote_resume;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Priority inside this process, lowest first:
  //   1. the reset and resume timers of the sequence state machine
  //   2. software commands written to the port register
  //   3. the controller entering its resume state
  //   4. faults, which always win over a software enable
  //   5. an absent device, which drops suspend and enable together
  // Later assignments override earlier ones, so a fault in the same cycle
  // as a set-enable write leaves the port disabled. That is the safe
  // outcome: software reads the enable bit clear and can retry.
  // Change flags are collected as set requests and merged at the end so
  // that a write-one-clear in the same cycle as a new event keeps the set.
  always_comb begin
    logic set_chg_attach;
    logic set_chg_suspend;
    logic set_chg_reset;
    logic set_chg_enable;
    set_chg_attach  = 1'b0;
    set_chg_suspend = 1'b0;
    set_chg_reset   = 1'b0;
    set_chg_enable  = 1'b0;
    next_state  = state;
    next_timer  = timer;
    next_port_enabled_flag = port_enabled_flag;
    next_attach_prev = device_attached_flag;
    next_nonremovable_port_mask = nonremovable_port_mask;
    if (wr_ctl) begin
      next_nonremovable_port_mask = bus_i.wdata[RHPS_CTL_NONREM];
    end

    // Sequence handling
    unique case (state)
      RHPS_IDLE: begin
        // Ignored as not running
      end
      RHPS_RESETTING: begin
        if (timer == '0) begin
          next_state    = RHPS_IDLE;
          set_chg_reset = 1'b1;
          next_port_enabled_flag = 1'b1;
        end else begin
          next_timer = timer - 1'b1;
        end
      end
      RHPS_SUSPENDED: begin
        if (port_s.remote_resume) begin
          next_state = RHPS_RESUMING;
          next_timer = RHPS_CNT_W'(RHPS_RESUME_CYCLES - 1);
        end
      end
      RHPS_RESUMING: begin
        if (timer == '0) begin
          next_state      = RHPS_IDLE;
          set_chg_suspend = 1'b1;
          next_port_enabled_flag = 1'b1;
        end else begin
          next_timer = timer - 1'b1;
        end
      end
    endcase

    // Software commands; changes on an absent device are refused
    if (wr_port) begin
      if (bus_i.wdata[RHPS_BIT_ATTACH]) begin
        next_port_enabled_flag = 1'b0;
      end
      if (bus_i.wdata[RHPS_BIT_ENABLE]) begin
        // set enable or flag attach change
        if (device_attached_flag) next_port_enabled_flag = 1'b1;
        else set_chg_attach = 1'b1;
      end
      if (bus_i.wdata[RHPS_BIT_SUSPEND]) begin
        // set suspend or flag attach change
        if (!device_attached_flag) begin
          set_chg_attach = 1'b1;
        end else if (state == RHPS_IDLE) begin
          next_state = RHPS_SUSPENDED;
        end
      end
      if (bus_i.wdata[RHPS_BIT_RESET]) begin
        if (!device_attached_flag) begin
          set_chg_attach = 1'b1;
        end else begin
          next_state = RHPS_RESETTING;
          next_timer = RHPS_CNT_W'(RHPS_RESET_CYCLES - 1);
        end
      end
    end

    if (controller_resume_state_i && port_suspended_flag) begin
      next_state = RHPS_IDLE;
    end

    // faults clear enable and flag it
    if (fault) begin
      if (port_enabled_flag) set_chg_enable = 1'b1;
      next_port_enabled_flag = 1'b0;
    end

    // disconnect drops suspend and enable together
    if (!device_attached_flag) begin
      next_port_enabled_flag = 1'b0;
      if (state != RHPS_IDLE) next_state = RHPS_IDLE;
    end
    if (disconnect || (device_attached_flag && !attach_prev)) begin
      set_chg_attach = 1'b1;
    end

    // Change flags: write one clears, a new event wins over the clear
    next_attach_change_flag  = set_chg_attach ||
      (attach_change_flag && !(wr_chg && bus_i.wdata[RHPS_CHG_ATTACH]));
    next_enable_change_flag  = set_chg_enable ||
      (enable_change_flag && !(wr_chg && bus_i.wdata[RHPS_CHG_ENABLE]));
    next_suspend_change_flag = set_chg_suspend ||
      (suspend_change_flag && !(wr_chg && bus_i.wdata[RHPS_CHG_SUSPEND]));
    next_reset_change_flag   = set_chg_reset ||
      (reset_change_flag && !(wr_chg && bus_i.wdata[RHPS_CHG_RESET]));

    // Read data, valid the cycle after the strobe
    next_rdata = 32'h0000_0000;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        RHPS_ADDR_PORT: begin
          next_rdata[RHPS_BIT_ATTACH]  = device_attached_flag;
          next_rdata[RHPS_BIT_ENABLE]  = port_enabled_flag;
          next_rdata[RHPS_BIT_SUSPEND] = port_suspended_flag;
          next_rdata[RHPS_BIT_RESET]   = port_reset_active_flag;
        end
        RHPS_ADDR_CHANGE: begin
          next_rdata[RHPS_CHG_ATTACH]  = attach_change_flag;
          next_rdata[RHPS_CHG_ENABLE]  = enable_change_flag;
          next_rdata[RHPS_CHG_SUSPEND] = suspend_change_flag;
          next_rdata[RHPS_CHG_RESET]   = reset_change_flag;
        end
        RHPS_ADDR_CTRL: begin
          next_rdata[RHPS_CTL_NONREM] = nonremovable_port_mask;
        end
        default: begin
          // Unmapped reads return zero
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Plain register stage for every piece of state computed above.
  // Reset is synchronous; the attach history starts at zero, so a device
  // already present when reset ends is reported once as an attach change.
  // Read data also resets to zero, matching the idle value of the bus.
  // The timer needs no particular reset value, but clearing it keeps the
  // first reset or resume sequence free of unknowns in simulation.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state                  <= RHPS_IDLE;
      timer                  <= '0;
      port_enabled_flag      <= 1'b0;
      attach_change_flag     <= 1'b0;
      enable_change_flag     <= 1'b0;
      suspend_change_flag    <= 1'b0;
      reset_change_flag      <= 1'b0;
      nonremovable_port_mask <= 1'b0;
      attach_prev            <= 1'b0;
      rdata_o                <= RHPS_RD_RESET;
    end else begin
      state                  <= next_state;
      timer                  <= next_timer;
      port_enabled_flag      <= next_port_enabled_flag;
      attach_change_flag     <= next_attach_change_flag;
      enable_change_flag     <= next_enable_change_flag;
      suspend_change_flag    <= next_suspend_change_flag;
      reset_change_flag      <= next_reset_change_flag;
      nonremovable_port_mask <= next_nonremovable_port_mask;
      attach_prev            <= next_attach_prev;
      rdata_o                <= next_rdata;
    end
  end
endmodule : rhps_port

// ---- rhps_port_props.sv ----
// Checker for the root hub port status logic
`timescale 1ns/10ps
module rhps_port_props (
  input wire logic                 sys_clk_i,
  input wire logic                 rst_i,
  input wire rhps_pkg::rhps_bus_t  bus_i,
  input wire logic [31:0]          rdata_o,
  input wire rhps_pkg::rhps_port_t port_i,
  input wire logic                 controller_resume_state_i,
  input wire logic                 port_reset_drive_o,
  input wire logic                 port_resume_drive_o,
  input wire logic                 resume_to_controller_o
);
  import rhps_pkg::*;
  int rcnt, next_rcnt;  // Cycles of reset drive so far
  int scnt, next_scnt;  // Cycles of resume drive so far
  // ---------------------------------------------------------------
  // Drive length counters
  // ---------------------------------------------------------------
  always_comb begin
    next_rcnt = (port_reset_drive_o && !rst_i) ? rcnt + 1 : 0;
    next_scnt = (port_resume_drive_o && !rst_i) ? scnt + 1 : 0;
  end
  always_ff @(posedge sys_clk_i) begin
    rcnt <= next_rcnt;
    scnt <= next_scnt;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_rd_quiet;
    !bus_i.rd |=> rdata_o == 32'h0000_0000;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read data not zero outside read slot");
  property p_rd_port;
    bus_i.rd && bus_i.addr == RHPS_ADDR_PORT |=> rdata_o[31:5] == '0
      && !rdata_o[3] && rdata_o[4] == $past(port_reset_drive_o)
      && (!$past(port_resume_drive_o) || rdata_o[2]);
  endproperty
  a_rd_port: assert property (p_rd_port)
    else $error("port read disagrees with port state");
  property p_rst_start;
    $rose(port_reset_drive_o) |-> $past(bus_i.wr
      && bus_i.addr == RHPS_ADDR_PORT && bus_i.wdata[RHPS_BIT_RESET]);
  endproperty
  a_rst_start: assert property (p_rst_start)
    else $error("reset drive began without a reset write");
  property p_rst_len;
    rcnt <= RHPS_RESET_CYCLES;
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("reset drive too long");
  property p_res_len;
    scnt <= RHPS_RESUME_CYCLES;
  endproperty
  a_res_len: assert property (p_res_len)
    else $error("resume drive too long");
  property p_res_start;
    $rose(port_resume_drive_o) |-> $past(resume_to_controller_o);
  endproperty
  a_res_start: assert property (p_res_start)
    else $error("resume began without a forwarded wake");
  property p_fwd;
    resume_to_controller_o |-> $past(port_i.remote_resume, 2);
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("resume forwarded without device wake");
  property p_ctl_res;
    controller_resume_state_i |=> !port_resume_drive_o;
  endproperty
  a_ctl_res: assert property (p_ctl_res)
    else $error("controller resume did not end port resume");
  c_rst: cover property ($fell(port_reset_drive_o));
  c_res: cover property ($fell(port_resume_drive_o));
  c_fwd: cover property (resume_to_controller_o);
endmodule : rhps_port_props

// ---- rhps_sync.sv ----
// Two-flop synchroniser for the port pin inputs
`timescale 1ns/10ps
module rhps_sync #(
  parameter int W = 5
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [W-1:0] meta;       // First stage, read only by the second
  logic [W-1:0] next_meta;  // Next first stage
  logic [W-1:0] next_q;     // Next second stage

  // Next values simply shift the chain
  always_comb begin
    next_meta = d_i;
    next_q    = meta;
  end

  // Reset to zero so no stale attach is seen
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end
endmodule : rhps_sync

// ---- tb.sv ----
// Self-checking testbench for the root hub port status logic
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb;
  import rhps_pkg::*;
  logic        sys_clk_i, rst_i, crs, rst_drv, res_drv, to_ctl, seen;
  rhps_bus_t   bus;
  rhps_port_t  pins;
  logic [31:0] rdata, q;
  int          fails, checked;
  int          m_att, m_en, m_sus, m_rst, m_chg, m_nr;  // Reference model
  rhps_port dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_i(bus),
    .rdata_o(rdata), .port_i(pins), .controller_resume_state_i(crs),
    .port_reset_drive_o(rst_drv), .port_resume_drive_o(res_drv),
    .resume_to_controller_o(to_ctl));
  rhps_dev_model dev_u (.sys_clk_i(sys_clk_i), .port_o(pins));
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // Model of a register write; no device unless attached or nonremovable
  task automatic mdl_wr(input logic [7:0] a, input logic [31:0] d);
    int nodev;
    nodev = !m_att && !m_nr;
    if (a == RHPS_ADDR_PORT) begin
      if (d[0]) m_en = 0;
      if (d[1]) begin if (nodev) m_chg |= 1; else m_en = 1; end
      if (d[2]) begin
        if (nodev) m_chg |= 1; else if (!m_rst && !m_sus) m_sus = 1;
      end
      if (d[4]) begin if (nodev) m_chg |= 1; else m_rst = 1; end
    end
    if (a == RHPS_ADDR_CHANGE) m_chg &= ~int'(d);
    if (a == RHPS_ADDR_CTRL) m_nr = d[0];
  endtask : mdl_wr
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    bus <= '0;
    mdl_wr(a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_i);
    bus <= '0;
    #1 q = rdata;
  endtask : rd
  task automatic chk_regs();
    rd(RHPS_ADDR_PORT);
    `CHK(q, 32'(m_rst<<4 | m_sus<<2 | m_en<<1 | (m_att | m_nr)))
    rd(RHPS_ADDR_CHANGE);
    `CHK(q, 32'(m_chg))
  endtask : chk_regs
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : idle
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // Watchdog sized well above the two long port timers
  initial begin
    #(5 * 20000);
    fails++;
    print_verdict();
  end
  initial begin
    rst_i = 1'b1;
    bus = '0;
    crs = 1'b0;
    {m_att, m_en, m_sus, m_rst, m_chg, m_nr} = '0;
    void'($urandom(33));
    idle(4);
    rst_i <= 1'b0;
    // Empty port: each command is refused with an attach change
    chk_regs();
    foreach (q[i]) if (i == 1 || i == 2 || i == 4) begin
      wr(RHPS_ADDR_PORT, 32'(1 << i));
      chk_regs();
      wr(RHPS_ADDR_CHANGE, 32'h0000_001F);
    end
    wr(8'h0C, $urandom());
    rd(8'h0C);
    `CHK(q, 32'h0000_0000)
    $display("test empty done");
    dev_u.plug(1'b1);
    m_att = 1;
    m_chg |= 1;
    idle(5);
    chk_regs();
    wr(RHPS_ADDR_PORT, 32'h0000_0002);
    chk_regs();
    wr(RHPS_ADDR_PORT, 32'h0000_0000);
    chk_regs();
    wr(RHPS_ADDR_PORT, 32'h0000_0001);
    chk_regs();
    $display("test enable done");
    wr(RHPS_ADDR_PORT, 32'h0000_0010);
    chk_regs();
    `CHK(rst_drv, 1'b1)
    idle(RHPS_RESET_CYCLES);
    {m_rst, m_en} = {32'd0, 32'd1};
    m_chg |= 16;
    chk_regs();
    $display("test reset done");
    wr(RHPS_ADDR_CHANGE, 32'h0000_001F);
    wr(RHPS_ADDR_PORT, 32'h0000_0004);
    chk_regs();
    fork dev_u.wake(); join_none
    seen = 1'b0;
    repeat (6) begin
      @(posedge sys_clk_i);
      #1;
      if (to_ctl === 1'b1) seen = 1'b1;
    end
    `CHK(seen, 1'b1)
    chk_regs();
    `CHK(res_drv, 1'b1)
    idle(RHPS_RESUME_CYCLES);
    {m_sus, m_en} = {32'd0, 32'd1};
    m_chg |= 4;
    chk_regs();
    `CHK(res_drv, 1'b0)
    $display("test resume done");
    wr(RHPS_ADDR_PORT, 32'h0000_0004);
    crs <= 1'b1;
    @(posedge sys_clk_i);
    crs <= 1'b0;
    m_sus = 0;
    chk_regs();
    for (int i = 0; i < 3; i++) begin
      wr(RHPS_ADDR_PORT, 32'h0000_0002);
      dev_u.fault(i);
      idle(3);
      m_chg |= m_en ? 2 : 0;
      m_en = 0;
      chk_regs();
    end
    $display("test fault done");
    wr(RHPS_ADDR_PORT, 32'h0000_0002);
    wr(RHPS_ADDR_PORT, 32'h0000_0004);
    dev_u.plug(1'b0);
    idle(5);
    {m_att, m_sus, m_en} = '0;
    m_chg |= 3;
    chk_regs();
    wr(RHPS_ADDR_CTRL, 32'h0000_0001);
    rd(RHPS_ADDR_CTRL);
    `CHK(q, 32'h0000_0001)
    chk_regs();
    $display("test removal done");
    print_verdict();
  end
endmodule : tb
bind rhps_port rhps_port_props props_u (.sys_clk_i(sys_clk_i),
  .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o), .port_i(port_i),
  .controller_resume_state_i(controller_resume_state_i),
  .port_reset_drive_o(port_reset_drive_o),
  .port_resume_drive_o(port_resume_drive_o),
  .resume_to_controller_o(resume_to_controller_o));
